// *** logic/dpx_point_exchange.sv ***
// Digital point exchange: status pair mapping, periodic resend, direct I/O
// Contract
// - Up to 32 operands placed into predefined pairs; the code places 25, in pairs 1-20 and 22-26
// - Up to 32 user pairs carry selected operands
// - Pair 3 signals remote reclose initiate
// - Pair 4 signals remote reclose block
// - Pair 5 carries breaker failure initiate
// - Pair 6 carries send transfer trip
// - Pairs 14-17 report breaker disconnect, closed=1
// - Pair 21 reports available=1, offline=0
// - Pair 27 reports test mode=1, normal=0
// - Resend message after configurable idle interval
// - Direct input accepts only configured source peer
// - Direct input bit equals sender output index
// - Offline source forces default-state policy value
// - Default On forces logic 1
// - Default Off forces logic 0
// - Latest/On holds last, else 1
// - Latest/Off holds last, else 0
// - Direct outputs follow their selected operand
// - Send after power-up and on any change
// - Hold time is three times interval
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module dpx_point_exchange
    import dpx_pkg::*;
#(
    parameter int TICK_CYC = DPX_TICK_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DPX_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Local operands and device state
    input wire logic [DPX_NOPS-1:0] operand_in,
    input wire logic dev_available,
    // Outgoing status message
    output logic msg_send,
    output logic [DPX_NPTS-1:0] predefined_status_pair,
    output logic [DPX_NPTS-1:0] user_status_pair,
    output logic [17:0] msg_hold_ms,
    // Direct outputs
    output logic [DPX_NPTS-1:0] direct_out,
    // Received peer data and link supervision
    input wire logic rx_valid,
    input wire logic [DPX_PEERW-1:0] rx_peer,
    input wire logic [DPX_NPTS-1:0] rx_bits,
    input wire logic [DPX_NPEER-1:0] peer_offline,
    // Direct inputs
    output logic [DPX_NPTS-1:0] direct_in
);

    // Operand picked by a selector field
    function automatic logic pick(input logic [DPX_NOPS-1:0] ops, input logic [7:0] sel);
        pick = ops[sel[DPX_SELW-1:0]];
    endfunction

    // Address lies inside a bank window
    function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base,
                                     input logic [11:0] span);
        in_bank = (a >= base) && (a < base + span);
    endfunction

    // Configuration storage
    logic ctrl_test_q; // Test mode flag
    logic [15:0] interval_q; // Resend interval in ms
    logic [7:0] pre_sel_q [DPX_NPTS]; // Predefined pair selectors
    logic [7:0] user_sel_q [DPX_NPTS]; // User pair selectors
    logic [7:0] dout_sel_q [DPX_NPTS]; // Direct output selectors
    logic [15:0] din_cfg_q [DPX_NPTS]; // Direct input peer, bit, policy

    // Bus handshake state
    logic ack_q; // Second access cycle marker
    logic [31:0] rdata_q; // Registered read data
    logic err_q; // Registered unmapped flag
    logic [31:0] rd_d; // Read mux
    logic hit_d; // Address is mapped
    logic wr_en; // Write commits this edge

    // Message state
    logic boot_q; // Power-up message pending
    logic send_q; // Send strobe
    logic [DPX_NPTS-1:0] pre_q; // Last sent predefined pairs
    logic [DPX_NPTS-1:0] user_q; // Last sent user pairs
    logic [DPX_NPTS-1:0] pre_d; // Live predefined pairs
    logic [DPX_NPTS-1:0] user_d; // Live user pairs
    logic [31:0] pre_cnt_q; // Cycles within a millisecond
    logic [15:0] ms_cnt_q; // Milliseconds since last send
    logic tick; // One millisecond elapsed
    logic expire; // Idle interval over
    logic change; // Any included point changed
    logic [17:0] hold_q; // Hold time sent with message

    // Direct point state
    logic [DPX_NPTS-1:0] dout_q; // Direct outputs
    logic [DPX_NPTS-1:0] last_q; // Last received per input
    logic [DPX_NPTS-1:0] known_q; // A value has arrived since reset
    logic [DPX_NPTS-1:0] din_q; // Direct inputs
    logic [DPX_NPTS-1:0] din_d; // Next direct inputs

    // Zero-wait setup, one-cycle access wait: data and error come from flops
    assign pready = ack_q;
    assign prdata = rdata_q;
    assign pslverr = err_q;
    assign wr_en = psel && penable && ack_q && pwrite && hit_d;

    // Read decode and mapped check
    always_comb begin
        rd_d = 32'h0000_0000;
        hit_d = 1'b1;
        if (in_bank(paddr, DPX_A_PRE_SEL, DPX_SEL_SPAN)) begin
            for (int k = 0; k < 4; k++) begin
                rd_d[8*k +: 8] = pre_sel_q[{paddr[4:2], 2'(k)}];
            end
        end else if (in_bank(paddr, DPX_A_USER_SEL, DPX_SEL_SPAN)) begin
            for (int k = 0; k < 4; k++) begin
                rd_d[8*k +: 8] = user_sel_q[{paddr[4:2], 2'(k)}];
            end
        end else if (in_bank(paddr, DPX_A_DOUT_SEL, DPX_SEL_SPAN)) begin
            for (int k = 0; k < 4; k++) begin
                rd_d[8*k +: 8] = dout_sel_q[{paddr[4:2], 2'(k)}];
            end
        end else if (in_bank(paddr, DPX_A_DIN_CFG, DPX_DIN_SPAN)) begin
            rd_d = {din_cfg_q[{paddr[5:2], 1'b1}], din_cfg_q[{paddr[5:2], 1'b0}]};
        end else begin
            case (paddr)
                DPX_A_CTRL: rd_d[DPX_CTRL_TEST] = ctrl_test_q;
                DPX_A_INTERVAL: rd_d[15:0] = interval_q;
                DPX_A_TX_PRE: rd_d = pre_q;
                DPX_A_TX_USER: rd_d = user_q;
                DPX_A_DIR_OUT: rd_d = dout_q;
                DPX_A_DIR_IN: rd_d = din_q;
                DPX_A_HOLD: rd_d[17:0] = hold_q;
                default: hit_d = 1'b0;
            endcase
        end
        // Misaligned addresses are not mapped
        if (paddr[1:0] != 2'b00) begin
            hit_d = 1'b0;
            rd_d = 32'h0000_0000;
        end
    end

    // Bus answer registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            ack_q <= psel && penable && !ack_q;
            if (psel && penable && !ack_q) begin
                rdata_q <= pwrite ? 32'h0000_0000 : rd_d;
                err_q <= !hit_d;
            end else begin
                err_q <= 1'b0;
            end
        end
    end

    // Scalar control registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_test_q <= 1'b0;
            interval_q <= DPX_INTERVAL_RST;
        end else if (wr_en && paddr == DPX_A_CTRL) begin
            ctrl_test_q <= pwdata[DPX_CTRL_TEST];
        end else if (wr_en && paddr == DPX_A_INTERVAL) begin
            interval_q <= pwdata[15:0];
        end
    end

    // Selector and direct input config banks, four or two entries per word
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DPX_NPTS; i++) begin
                pre_sel_q[i] <= DPX_SEL_RST;
                user_sel_q[i] <= DPX_SEL_RST;
                dout_sel_q[i] <= DPX_SEL_RST;
                din_cfg_q[i] <= DPX_DIN_CFG_RST;
            end
        end else if (wr_en) begin
            for (int k = 0; k < 4; k++) begin
                if (in_bank(paddr, DPX_A_PRE_SEL, DPX_SEL_SPAN)) begin
                    pre_sel_q[{paddr[4:2], 2'(k)}] <= pwdata[8*k +: 8];
                end
                if (in_bank(paddr, DPX_A_USER_SEL, DPX_SEL_SPAN)) begin
                    user_sel_q[{paddr[4:2], 2'(k)}] <= pwdata[8*k +: 8];
                end
                if (in_bank(paddr, DPX_A_DOUT_SEL, DPX_SEL_SPAN)) begin
                    dout_sel_q[{paddr[4:2], 2'(k)}] <= pwdata[8*k +: 8];
                end
            end
            if (in_bank(paddr, DPX_A_DIN_CFG, DPX_DIN_SPAN)) begin
                din_cfg_q[{paddr[5:2], 1'b0}] <= pwdata[15:0];
                din_cfg_q[{paddr[5:2], 1'b1}] <= pwdata[31:16];
            end
        end
    end

    // Live pair values; pairs 3-6 and 14-17 carry whatever operand software
    // maps to them (reclose, block, breaker failure, transfer trip, disconnect)
    always_comb begin
        for (int i = 0; i < DPX_NPTS; i++) begin
            pre_d[i] = pick(operand_in, pre_sel_q[i]);
            user_d[i] = pick(operand_in, user_sel_q[i]);
        end
        pre_d[DPX_PAIR_STATUS] = dev_available;
        pre_d[DPX_PAIR_MODE] = ctrl_test_q;
        // Reserved pairs always go out as zero
        for (int i = DPX_PAIR_RSV_LO; i < DPX_NPTS; i++) begin
            pre_d[i] = 1'b0;
        end
    end

    // Send triggers
    assign change = (pre_d != pre_q) || (user_d != user_q);
    assign tick = (pre_cnt_q == 32'(TICK_CYC - 1));
    // A zero interval is treated as one millisecond
    assign expire = tick && (ms_cnt_q + 16'h0001 >= interval_q);

    // Millisecond prescaler and idle timer, restarted by every send
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt_q <= 32'h0000_0000;
            ms_cnt_q <= 16'h0000;
        end else if (boot_q || change || expire) begin
            pre_cnt_q <= 32'h0000_0000;
            ms_cnt_q <= 16'h0000;
        end else if (tick) begin
            pre_cnt_q <= 32'h0000_0000;
            ms_cnt_q <= ms_cnt_q + 16'h0001;
        end else begin
            pre_cnt_q <= pre_cnt_q + 32'h0000_0001;
        end
    end

    // Message snapshot and send strobe
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            boot_q <= 1'b1;
            send_q <= 1'b0;
            pre_q <= '0;
            user_q <= '0;
            hold_q <= 18'h00000;
        end else begin
            boot_q <= 1'b0;
            send_q <= boot_q || change || expire;
            if (boot_q || change || expire) begin
                pre_q <= pre_d;
                user_q <= user_d;
                hold_q <= 18'(DPX_HOLD_MULT * 18'(interval_q));
            end
        end
    end

    assign msg_send = send_q;
    assign predefined_status_pair = pre_q;
    assign user_status_pair = user_q;
    assign msg_hold_ms = hold_q;

    // Direct outputs track their operands, one cycle late
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dout_q <= '0;
        end else begin
            for (int i = 0; i < DPX_NPTS; i++) begin
                dout_q[i] <= pick(operand_in, dout_sel_q[i]);
            end
        end
    end

    assign direct_out = dout_q;

    // Capture from the configured peer only; data from a peer marked offline
    // is ignored so a stale frame cannot refresh a frozen value
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            last_q <= '0;
            known_q <= '0;
        end else begin
            for (int i = 0; i < DPX_NPTS; i++) begin
                if (rx_valid && rx_peer == din_cfg_q[i][DPX_PEERW-1:0]
                        && !peer_offline[din_cfg_q[i][DPX_PEERW-1:0]]) begin
                    last_q[i] <= rx_bits[din_cfg_q[i][DPX_CFG_BIT_LO +: 5]];
                    known_q[i] <= 1'b1;
                end
            end
        end
    end

    // Default-state policy while offline or before the first value
    always_comb begin
        for (int i = 0; i < DPX_NPTS; i++) begin
            if (!peer_offline[din_cfg_q[i][DPX_PEERW-1:0]] && known_q[i]) begin
                din_d[i] = last_q[i];
            end else begin
                case (din_cfg_q[i][DPX_CFG_DEF_LO +: 2])
                    DPX_DEF_ON: din_d[i] = 1'b1;
                    DPX_DEF_OFF: din_d[i] = 1'b0;
                    DPX_DEF_LAT_ON: din_d[i] = known_q[i] ? last_q[i] : 1'b1;
                    DPX_DEF_LAT_OFF: din_d[i] = known_q[i] ? last_q[i] : 1'b0;
                    default: din_d[i] = 1'b0;
                endcase
            end
        end
    end

    // Direct inputs registered
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            din_q <= '0;
        end else begin
            din_q <= din_d;
        end
    end

    assign direct_in = din_q;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_access_wait;
        psel && penable && !ack_q ##1 psel && penable;
    endsequence

    chk_apb_one_wait: assert property (s_access_wait |-> pready)
        else $error("pready not given on second access cycle");
    chk_reserved_zero: assert property (msg_send |-> predefined_status_pair[31:27] == 5'h00)
        else $error("reserved pair carried a value");
    chk_status_pair: assert property (msg_send |-> predefined_status_pair[20] == $past(dev_available))
        else $error("status pair does not follow availability");
    chk_mode_pair: assert property (msg_send |-> predefined_status_pair[26] == $past(ctrl_test_q))
        else $error("mode pair does not follow test flag");
    chk_change_send: assert property (change && !sys_rst |=> msg_send)
        else $error("change of state not sent");
    chk_hold_three: assert property (msg_send |-> msg_hold_ms == 18'(3 * $past(interval_q)))
        else $error("hold time not three times interval");
    chk_dout_follow: assert property ($stable(dout_sel_q[0]) && $stable(operand_in)
            |=> direct_out[0] == pick($past(operand_in), $past(dout_sel_q[0])))
        else $error("direct output 0 does not follow operand");
    chk_offline_on: assert property (peer_offline[din_cfg_q[0][3:0]]
            && din_cfg_q[0][10:9] == DPX_DEF_ON |=> direct_in[0])
        else $error("offline On default not forced high");
    // Entry 1 is the one the bench sets to Off, so the check is reached
    chk_offline_off: assert property (peer_offline[din_cfg_q[1][3:0]]
            && din_cfg_q[1][10:9] == DPX_DEF_OFF |=> !direct_in[1])
        else $error("offline Off default not forced low");
    // Entry 2 runs a Latest policy in the bench
    chk_latest_hold: assert property (peer_offline[din_cfg_q[2][3:0]] && known_q[2]
            && din_cfg_q[2][10] |=> direct_in[2] == $past(last_q[2]))
        else $error("latest policy did not hold last value");
    chk_wrong_peer: assert property (rx_valid && rx_peer != din_cfg_q[0][3:0]
            |=> last_q[0] == $past(last_q[0]))
        else $error("direct input took data from wrong peer");

endmodule

// *** common/dpx_pkg.sv ***
// Shared constants for the digital point exchange block
package dpx_pkg;
    // Point counts and widths
    localparam int DPX_NPTS = 32;
    localparam int DPX_NOPS = 128;
    localparam int DPX_SELW = 7;
    localparam int DPX_NPEER = 16;
    localparam int DPX_PEERW = 4;
    localparam int DPX_AW = 12;
    // Fixed meaning of predefined pairs, zero based (pair n sits at bit n-1)
    localparam int DPX_PAIR_STATUS = 20;
    localparam int DPX_PAIR_MODE = 26;
    localparam int DPX_PAIR_RSV_LO = 27;
    // Register byte addresses
    localparam logic [11:0] DPX_A_CTRL = 12'h000;
    localparam logic [11:0] DPX_A_INTERVAL = 12'h004;
    localparam logic [11:0] DPX_A_TX_PRE = 12'h008;
    localparam logic [11:0] DPX_A_TX_USER = 12'h00c;
    localparam logic [11:0] DPX_A_DIR_OUT = 12'h010;
    localparam logic [11:0] DPX_A_DIR_IN = 12'h014;
    localparam logic [11:0] DPX_A_HOLD = 12'h018;
    localparam logic [11:0] DPX_A_PRE_SEL = 12'h040;
    localparam logic [11:0] DPX_A_USER_SEL = 12'h060;
    localparam logic [11:0] DPX_A_DOUT_SEL = 12'h080;
    localparam logic [11:0] DPX_A_DIN_CFG = 12'h100;
    // Window sizes of the selector and config banks, in bytes
    localparam logic [11:0] DPX_SEL_SPAN = 12'h020;
    localparam logic [11:0] DPX_DIN_SPAN = 12'h040;
    // Field positions
    localparam int DPX_CTRL_TEST = 0;
    localparam int DPX_CFG_BIT_LO = 4;
    localparam int DPX_CFG_DEF_LO = 9;
    // Default-state policy codes
    localparam logic [1:0] DPX_DEF_ON = 2'h0;
    localparam logic [1:0] DPX_DEF_OFF = 2'h1;
    localparam logic [1:0] DPX_DEF_LAT_ON = 2'h2;
    localparam logic [1:0] DPX_DEF_LAT_OFF = 2'h3;
    // Reset values
    localparam logic [15:0] DPX_INTERVAL_RST = 16'h03e8;
    localparam logic [15:0] DPX_DIN_CFG_RST = 16'h0000;
    localparam logic [7:0] DPX_SEL_RST = 8'h00;
    // Hold time multiple of the resend interval
    localparam logic [17:0] DPX_HOLD_MULT = 18'h00003;
    // Timing: one resend tick is one millisecond
    localparam int DPX_CLK_NS = 8;
    localparam int DPX_TICK_NS = 1000000;
    localparam int DPX_TICK_CYC = DPX_TICK_NS / DPX_CLK_NS;
endpackage

// *** dv/dpx_peer_model.sv ***
// Peer relay model: direct output words and link supervision
`timescale 1ns/1ps
module dpx_peer_model
    import dpx_pkg::*;
(
    // Clock
    input wire logic clock,
    // Peer data and supervision
    output logic rx_valid,
    output logic [DPX_PEERW-1:0] rx_peer,
    output logic [DPX_NPTS-1:0] rx_bits,
    output logic [DPX_NPEER-1:0] peer_offline
);
    // Quiet link, every peer online
    initial begin
        rx_valid = 1'b0;
        rx_peer = '0;
        rx_bits = '0;
        peer_offline = '0;
    end
    // One message after gap idle cycles; bit n is our direct output n
    task automatic send(input logic [3:0] p, input logic [31:0] b, input int gap);
        repeat (gap) @(posedge clock);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_peer <= p;
        rx_bits <= b;
        @(posedge clock);
        rx_valid <= 1'b0;
        // Stale fields scrambled so nothing leans on them
        rx_peer <= ~p;
        rx_bits <= ~b;
    endtask
    // Supervision verdict, 1 means offline
    task automatic set_offline(input int p, input logic v);
        @(posedge clock);
        peer_offline[p] <= v;
    endtask
endmodule

// *** dv/dpx_point_exchange_tb.sv ***
// Self-checking bench for the digital point exchange block
`timescale 1ns/1ps
module dpx_point_exchange_tb;
    import dpx_pkg::*;
    localparam int TICK = 4; // Short tick keeps resend counts small
    localparam logic [127:0] OPV = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    // Design stimulus and observation
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, predefined_status_pair, user_status_pair, direct_out, direct_in;
    logic pready, pslverr, msg_send, rx_valid;
    logic [127:0] operand_in = '0;
    logic dev_available = 1'b1;
    logic [17:0] msg_hold_ms;
    logic [3:0] rx_peer;
    logic [31:0] rx_bits;
    logic [15:0] peer_offline;
    // Bookkeeping
    int failures = 0;
    int checked = 0;
    logic [31:0] rd;
    logic err;
    always #4 clock = ~clock;
    dpx_point_exchange #(.TICK_CYC(TICK)) i_dpx_point_exchange (.clock(clock),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .operand_in(operand_in), .dev_available(dev_available), .msg_send(msg_send),
        .predefined_status_pair(predefined_status_pair), .user_status_pair(user_status_pair),
        .msg_hold_ms(msg_hold_ms), .direct_out(direct_out), .rx_valid(rx_valid),
        .rx_peer(rx_peer), .rx_bits(rx_bits), .peer_offline(peer_offline),
        .direct_in(direct_in));
    dpx_peer_model i_dpx_peer_model (.clock(clock), .rx_valid(rx_valid), .rx_peer(rx_peer),
        .rx_bits(rx_bits), .peer_offline(peer_offline));
    // Verdict and end of run
    task automatic results();
        $display("Summary: %0d checks, %0d failures", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // A wait that ran out ends the run
    task automatic hang(input string what);
        failures++;
        $display("unexpected %s: expected response, seen none", what);
        results();
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) hang("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Edges until the next message pulse, bounded
    task automatic wait_msg(input int lim, output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (msg_send !== 1'b1 && n < lim);
        if (msg_send !== 1'b1) hang("msg_send");
    endtask
    // Predefined pairs: entry e carries operand e+40, fixed pairs overridden
    function automatic logic [31:0] exp_pre(input logic [127:0] op, input logic av,
                                            input logic tm);
        logic [31:0] v;
        v = '0;
        for (int e = 0; e < 27; e++) v[e] = op[e+40];
        v[DPX_PAIR_STATUS] = av;
        v[DPX_PAIR_MODE] = tm;
        return v;
    endfunction
    // Power-up message, reset values, unmapped access
    task automatic t_reset();
        int n;
        wait_msg(4, n);
        chk("hold time", 3 * DPX_INTERVAL_RST, 32'(msg_hold_ms));
        apb(1'b0, DPX_A_INTERVAL, '0);
        chk("interval reset", 32'(DPX_INTERVAL_RST), rd);
        chk("mapped error", 0, 32'(err));
        apb(1'b0, DPX_A_HOLD, '0);
        chk("hold register", 3 * DPX_INTERVAL_RST, rd);
        apb(1'b0, DPX_A_INTERVAL + 12'h002, '0);
        chk("misaligned error", 1, 32'(err));
        apb(1'b0, 12'h200, '0);
        chk("unmapped error", 1, 32'(err));
    endtask
    // Resend period and hold time follow the interval
    task automatic t_interval();
        int n;
        apb(1'b1, DPX_A_INTERVAL, 32'h2);
        wait_msg(5000, n);
        wait_msg(20, n);
        chk("resend period", 2 * TICK, n);
        chk("hold time", 32'h6, 32'(msg_hold_ms));
    endtask
    // Selector banks, fixed pairs, change-triggered messages
    task automatic t_map();
        logic [31:0] v;
        logic [127:0] op;
        int n;
        int prs[8] = '{3, 4, 5, 6, 14, 15, 16, 17};
        for (int w = 0; w < 8; w++) begin
            for (int k = 0; k < 4; k++) v[8*k +: 8] = 8'(4 * w + k);
            apb(1'b1, DPX_A_PRE_SEL + 12'(4 * w), v + 32'h2828_2828);
            apb(1'b1, DPX_A_USER_SEL + 12'(4 * w), v + 32'h5050_5050);
            apb(1'b1, DPX_A_DOUT_SEL + 12'(4 * w), v);
        end
        apb(1'b0, DPX_A_PRE_SEL + 12'h004, '0);
        chk("selector readback", 32'h2f2e_2d2c, rd);
        apb(1'b1, DPX_A_CTRL, 32'h1);
        operand_in <= OPV;
        op = OPV;
        repeat (3) @(posedge clock);
        wait_msg(20, n);
        wait_msg(20, n);
        chk("predefined", exp_pre(op, 1'b1, 1'b1), predefined_status_pair);
        chk("user pairs", op[111:80], user_status_pair);
        chk("direct out", op[31:0], direct_out);
        // Long interval so only changes send
        apb(1'b1, DPX_A_INTERVAL, 32'h3e8);
        repeat (3) @(posedge clock);
        foreach (prs[i]) begin
            op[prs[i] + 39] = ~op[prs[i] + 39];
            operand_in <= op;
            wait_msg(4, n);
            chk("changed pair", exp_pre(op, 1'b1, 1'b1), predefined_status_pair);
        end
        dev_available <= 1'b0;
        wait_msg(4, n);
        chk("status pair", exp_pre(op, 1'b0, 1'b1), predefined_status_pair);
        apb(1'b1, DPX_A_CTRL, 32'h0);
        wait_msg(4, n);
        chk("mode pair", exp_pre(op, 1'b0, 1'b0), predefined_status_pair);
        apb(1'b0, DPX_A_TX_PRE, '0);
        chk("sent pairs register", exp_pre(op, 1'b0, 1'b0), rd);
    endtask
    // Direct inputs: source, bit number, the four default policies
    task automatic t_direct();
        logic [15:0] c[4];
        for (int e = 0; e < 4; e++) c[e] = 16'((e << 9) | ((e + 5) << 4) | 2);
        apb(1'b1, DPX_A_DIN_CFG, {c[1], c[0]});
        apb(1'b1, DPX_A_DIN_CFG + 12'h004, {c[3], c[2]});
        repeat (3) @(posedge clock);
        chk("no data yet", 32'hffff_fff5, direct_in);
        apb(1'b0, DPX_A_DIN_CFG, '0);
        chk("input config", {c[1], c[0]}, rd);
        apb(1'b0, DPX_A_DIR_IN, '0);
        chk("input register", 32'hffff_fff5, rd);
        i_dpx_peer_model.send(4'h3, 32'hffff_ffff, 0);
        repeat (3) @(posedge clock);
        chk("other peer", 32'hffff_fff5, direct_in);
        i_dpx_peer_model.send(4'h2, 32'h0000_0140, 2);
        repeat (3) @(posedge clock);
        chk("tracking", 32'hffff_fffa, direct_in);
        i_dpx_peer_model.set_offline(2, 1'b1);
        repeat (3) @(posedge clock);
        chk("offline", 32'hffff_fff9, direct_in);
        i_dpx_peer_model.send(4'h2, 32'hffff_febf, 0);
        repeat (3) @(posedge clock);
        chk("offline data", 32'hffff_fff9, direct_in);
        i_dpx_peer_model.set_offline(2, 1'b0);
        i_dpx_peer_model.send(4'h2, 32'h0000_01e0, 0);
        repeat (3) @(posedge clock);
        chk("resumed", 32'hffff_ffff, direct_in);
    endtask
    // Main sequence: reset held two cycles
    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset();
        t_interval();
        t_map();
        t_direct();
        results();
    end
endmodule
